// File: frbc_frame_sink.sv
// Framing-layer model: pops committed data words, keeps them in order.
// Assumes fd_valid and fd_data follow a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none

module frbc_frame_sink
  import frbc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [1:0]  stall_mode,
  input  wire logic        fd_valid,
  input  wire logic [31:0] fd_data,
  output var  logic        fd_ready
);
  logic [31:0] got [0:127];
  int          cnt;
  logic        phase;

  // Ready always, every other cycle, or never
  assign fd_ready = (stall_mode == 2'h0) | ((stall_mode == 2'h1) & phase);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt   <= 0;
      phase <= 1'b0;
    end
    else
    begin
      phase <= ~phase;
      if (fd_valid && fd_ready)
      begin
        got[cnt] <= fd_data;
        cnt      <= cnt + 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: frbc_pkg.sv
// Shared constants and types for the receive frame buffer and checksum.
// Assumes words arrive already classified by the word-identification
// machine, four characters a word, character 0 in the low byte.
`default_nettype none

package frbc_pkg;

  localparam int          FRBC_WIDTH    = 32;
  localparam int          FRBC_DEPTH    = 32;
  localparam logic [15:0] CRC16_POLY    = 16'h1021;
  localparam logic [15:0] CRC16_INIT    = 16'hffff;
  localparam logic [7:0]  CRC8_POLY     = 8'h07;
  localparam logic [7:0]  CRC8_INIT     = 8'h00;
  localparam logic [1:0]  BC_WORDS      = 2'h2;
  localparam logic [5:0]  BITS_WORD     = 6'h20;
  localparam logic [5:0]  BITS_EDF_COV  = 6'h10;
  localparam logic [5:0]  BITS_CTRL_COV = 6'h18;

  typedef enum logic [3:0] {
    wk_data,
    wk_start_data,
    wk_end_data,
    wk_start_bc,
    wk_end_bc,
    wk_flow_credit,
    wk_ack,
    wk_nack,
    wk_full,
    wk_other
  } frbc_kind_t;

  typedef enum logic [2:0] {
    no_frame_state,
    data_frame_state,
    broadcast_frame_state,
    broadcast_in_data_state,
    idle_frame_state
  } frbc_state_t;

  typedef struct packed {
    frbc_kind_t  kind;
    logic [3:0]  kflag;
    logic [31:0] data;
  } frbc_word_t;

endpackage

`default_nettype wire

// File: frbc_rx_buffer.sv
// Receive frame buffering with 16-bit and 8-bit checksum checking.
// Assumes the sequence check result arrives with each end/credit word
// and the framing layer drains the data buffer with valid and ready.
// What this block does
// - Hold frame words until checksum and sequence pass
// - Forward only good, in-sequence frames and flow credits
// - Drop any frame or credit with error or bad sequence
// - Data buffer takes data words only in data-frame state
// - Broadcast buffer takes data words in both broadcast states
// - Start words clear their own buffer
// - Entering no-frame state clears both buffers
// - Clean end-of-data word releases the data frame
// - Clean end-of-broadcast with two words releases the broadcast
// - Cold reset, warm reset or remote flush empties both buffers
// - Data frames carry a CCITT 16-bit checksum
// - 16-bit coverage runs from start comma to end sequence field
// - Control characters count as their data values
// - Packet end and fill codes count as data values
// - 16-bit checksum takes bit 0 of character 0 first
// - 8-bit checksum guards broadcast, credit, full, ack, nack
// - Broadcast coverage runs from start comma to end sequence
// - 8-bit generator is x^8 + x^2 + x + 1, modulo 2
// - Bytes in order, bit 0 of each byte first
// - Galois register starting at zero gives the remainder
// - Checksum byte is the remainder bit-reversed
// - Check by comparing computed byte with received byte
`timescale 1ns/1ps
`default_nettype none

module frbc_fifo
  import frbc_pkg::*;
#(
  parameter int WIDTH = FRBC_WIDTH,
  parameter int DEPTH = FRBC_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  input  wire logic             commit,
  input  wire logic             discard
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr;
  logic [AW:0]      rd;
  logic [AW:0]      cmt;
  logic [AW:0]      next_wr;
  logic [AW:0]      next_rd;
  logic [AW:0]      next_cmt;
  logic             next_ready;
  logic             next_valid;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready && !discard;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd[AW-1:0]];

  // Reader sees only committed words
  always_comb
  begin
    next_wr  = discard ? cmt : wr + (AW+1)'(push);
    next_rd  = rd + (AW+1)'(pop);
    next_cmt = commit ? wr : cmt;
    next_ready = (next_wr - next_rd) != (AW+1)'(DEPTH);
    next_valid = next_rd != next_cmt;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr        <= '0;
      rd        <= '0;
      cmt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr        <= next_wr;
      rd        <= next_rd;
      cmt       <= next_cmt;
      in_ready  <= next_ready;
      out_valid <= next_valid;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr[AW-1:0]] <= in_data;
  end
endmodule

module frbc_rx_buffer
  import frbc_pkg::*;
#(
  parameter int DEPTH = FRBC_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        rx_valid,
  input  wire frbc_word_t  rx_word,
  output var  logic        rx_ready,
  input  wire frbc_state_t id_state,
  input  wire logic        seq_ok,
  input  wire logic        cold_reset,
  input  wire logic        warm_reset,
  input  wire logic        remote_flush,
  output var  logic        fd_valid,
  output var  logic [31:0] fd_data,
  input  wire logic        fd_ready,
  output var  logic        bc_valid,
  output var  logic [63:0] bc_data,
  output var  logic        fct_valid,
  output var  logic        crc_error
);
  // Bit-serial CCITT update, bit 0 of character 0 first
  function automatic logic [15:0] crc16_upd(input logic [15:0] c,
                                            input logic [31:0] d,
                                            input logic [5:0]  nb);
    for (int i = 0; i < 32; i++)
      if (i < int'(nb))
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction
  function automatic logic [7:0] crc8_upd(input logic [7:0]  c,
                                          input logic [31:0] d,
                                          input logic [5:0]  nb);
    for (int i = 0; i < 32; i++)
      if (i < int'(nb))
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction
  // Bit-reversed copy of a byte
  function automatic logic [7:0] rev8(input logic [7:0] r);
    return {<<{r}};
  endfunction

  logic [15:0]  crc16;
  logic [7:0]   crc8;
  logic [1:0]   bcnt;
  logic [31:0]  bcbuf [2];
  frbc_state_t  last_state;
  logic [15:0]  next_crc16;
  logic [7:0]   next_crc8;
  logic [1:0]   next_bcnt;
  logic [31:0]  next_bcbuf [2];
  logic         next_bc_valid;
  logic [63:0]  next_bc_data;
  logic         next_fct_valid;
  logic         next_crc_error;
  logic [31:0]  wd;
  logic         acc;
  logic         in_df;
  logic         in_bc;
  logic         flush_req;
  logic         enter_nf;
  logic         edf_ok;
  logic         ebf_ok;
  logic         ctrl_ok;
  logic         df_push;
  logic         df_commit;
  logic         df_discard;

  assign wd        = rx_word.data;
  assign acc       = rx_valid && rx_ready;
  assign in_df     = id_state == data_frame_state;
  assign in_bc     = id_state == broadcast_frame_state ||
                     id_state == broadcast_in_data_state;
  assign flush_req = cold_reset || warm_reset || remote_flush;
  assign enter_nf  = id_state == no_frame_state &&
                     last_state != no_frame_state;
  // End word adds comma and sequence field
  assign edf_ok  = crc16_upd(crc16, wd, BITS_EDF_COV) == wd[31:16];
  assign ebf_ok  = rev8(crc8_upd(crc8, wd, BITS_CTRL_COV)) == wd[31:24];
  // Short words checked over three covered bytes
  assign ctrl_ok = rev8(crc8_upd(CRC8_INIT, wd, BITS_CTRL_COV))
                   == wd[31:24];
  // Data words in data-frame state only
  assign df_push = acc && rx_word.kind == wk_data && in_df;

  always_comb
  begin
    next_crc16     = crc16;
    next_crc8      = crc8;
    next_bcnt      = bcnt;
    next_bcbuf     = bcbuf;
    next_bc_valid  = 1'b0;
    next_bc_data   = bc_data;
    next_fct_valid = 1'b0;
    next_crc_error = 1'b0;
    df_commit      = 1'b0;
    df_discard     = 1'b0;
    if (acc)
    begin
      unique case (rx_word.kind)
        wk_start_data:
        begin
          df_discard = 1'b1;
          // Seed and take whole start word
          next_crc16 = crc16_upd(CRC16_INIT, wd, BITS_WORD);
        end
        wk_start_bc:
        begin
          next_bcnt = 2'h0;
          next_crc8 = crc8_upd(CRC8_INIT, wd, BITS_WORD);
        end
        wk_data:
        begin
          if (in_df)
          begin
            next_crc16 = crc16_upd(crc16, wd, BITS_WORD);
          end
          if (in_bc)
          begin
            next_crc8 = crc8_upd(crc8, wd, BITS_WORD);
            if (bcnt < BC_WORDS)
              next_bcbuf[bcnt[0]] = wd;
            if (bcnt != 2'h3)
              next_bcnt = bcnt + 2'h1;
          end
        end
        wk_end_data:
        begin
          if (in_df)
          begin
            df_commit  = edf_ok && seq_ok;
            df_discard = !(edf_ok && seq_ok);
            next_crc_error = !edf_ok;
          end
        end
        wk_end_bc:
        begin
          if (in_bc)
          begin
            next_bc_valid  = ebf_ok && seq_ok && bcnt == BC_WORDS;
            next_bc_data   = {bcbuf[1], bcbuf[0]};
            next_crc_error = !ebf_ok;
            next_bcnt      = 2'h0;
          end
        end
        wk_flow_credit:
        begin
          next_fct_valid = ctrl_ok && seq_ok;
          next_crc_error = !ctrl_ok;
        end
        wk_ack, wk_nack, wk_full:
        begin
          // Short words guarded by 8-bit check
          next_crc_error = !ctrl_ok;
        end
        wk_other:
        begin
        end
      endcase
    end
    // Leaving frames or reset empties buffers
    if (enter_nf || flush_req)
    begin
      df_discard = 1'b1;
      df_commit  = 1'b0;
      next_bcnt  = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      crc16      <= CRC16_INIT;
      crc8       <= CRC8_INIT;
      bcnt       <= 2'h0;
      bcbuf      <= '{default: 32'h0000_0000};
      last_state <= no_frame_state;
      bc_valid   <= 1'b0;
      bc_data    <= 64'h0;
      fct_valid  <= 1'b0;
      crc_error  <= 1'b0;
    end
    else
    begin
      crc16      <= next_crc16;
      crc8       <= next_crc8;
      bcnt       <= next_bcnt;
      bcbuf      <= next_bcbuf;
      last_state <= id_state;
      bc_valid   <= next_bc_valid;
      bc_data    <= next_bc_data;
      fct_valid  <= next_fct_valid;
      crc_error  <= next_crc_error;
    end
  end
  frbc_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) frbc_fifo_inst (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (df_push),
    .in_data   (wd),
    .in_ready  (rx_ready),
    .out_valid (fd_valid),
    .out_data  (fd_data),
    .out_ready (fd_ready),
    .commit    (df_commit),
    .discard   (df_discard)
  );
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_held_until_ok: assert property (
    frbc_fifo_inst.cmt != $past(frbc_fifo_inst.cmt) |->
      $past(acc && rx_word.kind == wk_end_data && edf_ok && seq_ok))
    else $error("data frame committed without clean end word");
  a_fct_forward: assert property (
    fct_valid |-> $past(acc && rx_word.kind == wk_flow_credit && seq_ok))
    else $error("flow credit forwarded without valid word");
  a_bc_seq_drop: assert property (
    acc && rx_word.kind == wk_end_bc && !seq_ok |=> !bc_valid)
    else $error("out of sequence broadcast forwarded");
  a_df_capture: assert property (
    df_push && !flush_req && !enter_nf |=>
      frbc_fifo_inst.wr == $past(frbc_fifo_inst.wr) + 6'h01)
    else $error("data word not captured");
  a_sdf_clear: assert property (
    acc && rx_word.kind == wk_start_data |=>
      frbc_fifo_inst.wr == $past(frbc_fifo_inst.cmt))
    else $error("start word did not clear data buffer");
  a_nf_clear: assert property (
    enter_nf |=> bcnt == 2'h0 && frbc_fifo_inst.wr == frbc_fifo_inst.cmt)
    else $error("no-frame entry left buffers filled");
  a_bc_release: assert property (
    bc_valid |-> $past(bcnt) == BC_WORDS && !crc_error)
    else $error("broadcast released with wrong word count");
  a_flush_empty: assert property (
    flush_req |=> bcnt == 2'h0 && frbc_fifo_inst.wr == frbc_fifo_inst.cmt)
    else $error("reset request did not empty buffers");
  a_crc_flag: assert property (
    acc && rx_word.kind == wk_end_data && in_df && !edf_ok |=>
      crc_error && !bc_valid)
    else $error("checksum mismatch not flagged");
endmodule

`default_nettype wire

// File: frbc_rx_buffer_test.sv
// Self-checking bench for the receive frame buffer and checksums.
// Assumes frbc_pkg, the design and frbc_frame_sink compile first.
`timescale 1ns/1ps
`default_nettype none

module frbc_rx_buffer_test
  import frbc_pkg::*;
  ;
  localparam int D = 32;
  logic        clock;
  logic        rstn;
  logic        rx_valid;
  frbc_word_t  rx_word;
  logic        rx_ready;
  frbc_state_t id_state;
  logic        seq_ok;
  logic        cold_reset;
  logic        warm_reset;
  logic        remote_flush;
  logic        fd_valid;
  logic [31:0] fd_data;
  logic        fd_ready;
  logic        bc_valid;
  logic [63:0] bc_data;
  logic        fct_valid;
  logic        crc_error;
  logic [1:0]  mode;
  int          err_total;
  int          num_checks;
  int          seen;
  logic [15:0] c16;
  logic [31:0] pend [$];
  logic [31:0] exp_w [$];

  frbc_rx_buffer #(.DEPTH(D)) frbc_rx_buffer_inst (
    .clock(clock), .rstn(rstn), .rx_valid(rx_valid), .rx_word(rx_word),
    .rx_ready(rx_ready), .id_state(id_state), .seq_ok(seq_ok),
    .cold_reset(cold_reset), .warm_reset(warm_reset),
    .remote_flush(remote_flush), .fd_valid(fd_valid), .fd_data(fd_data),
    .fd_ready(fd_ready), .bc_valid(bc_valid), .bc_data(bc_data),
    .fct_valid(fct_valid), .crc_error(crc_error));

  frbc_frame_sink frbc_frame_sink_inst (
    .clock(clock), .rstn(rstn), .stall_mode(mode), .fd_valid(fd_valid),
    .fd_data(fd_data), .fd_ready(fd_ready));

  function automatic logic [15:0] f16(logic [15:0] c, logic [31:0] d,
                                      int n);
    for (int i = 0; i < n; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0);
    return c;
  endfunction

  function automatic logic [7:0] f8(logic [7:0] c, logic [31:0] d, int n);
    for (int i = 0; i < n; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h0);
    return c;
  endfunction

  function automatic logic [7:0] rev8(logic [7:0] r);
    for (int i = 0; i < 8; i++)
      rev8[i] = r[7 - i];
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(logic [63:0] got, logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(frbc_kind_t k, frbc_state_t s, logic [31:0] d,
                      logic sq);
    int n;
    n = 0;
    #1;
    rx_valid = 1'b1;
    rx_word = '{k, 4'h0, d};
    id_state = s;
    seq_ok = sq;
    do
    begin
      @(posedge clock);
      n++;
    end while (rx_ready !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      err_total++;
      end_of_test();
    end
  endtask

  // Release the lane and look at the end-word pulses
  task automatic fin(logic e, logic b, logic f);
    #1;
    rx_valid = 1'b0;
    check(crc_error, e);
    check(bc_valid, b);
    check(fct_valid, f);
    @(posedge clock);
  endtask

  task automatic df_start();
    c16 = f16(CRC16_INIT, 32'h030201fc, 32);
    pend = {};
    send(wk_start_data, data_frame_state, 32'h030201fc, 1'b0);
  endtask

  // Data words carry the packet-end code value fd
  task automatic df_words(int n);
    logic [31:0] w;
    for (int i = 0; i < n; i++)
    begin
      w = {8'h6a, 8'(i), 8'hfd, 8'h1c};
      c16 = f16(c16, w, 32);
      pend.push_back(w);
      send(wk_data, data_frame_state, w, 1'b0);
    end
  endtask

  task automatic df_end(logic bad, logic sq, logic chk);
    logic [31:0] e;
    e = 32'h000011fc;
    c16 = f16(c16, e, 16);
    e[31:16] = c16 ^ {15'h0, bad};
    send(wk_end_data, data_frame_state, e, sq);
    if (chk)
      fin(bad, 1'b0, 1'b0);
    else
    begin
      #1;
      rx_valid = 1'b0;
      @(posedge clock);
    end
    if (!bad && sq && chk)
      exp_w = {exp_w, pend};
  endtask

  task automatic bcast(frbc_state_t st, int nw, logic bad, logic sq);
    logic [7:0]  c8;
    logic [31:0] w;
    logic [63:0] bd;
    logic        ok;
    c8 = f8(CRC8_INIT, 32'h060504fc, 32);
    bd = 64'h0;
    send(wk_start_bc, st, 32'h060504fc, 1'b0);
    for (int i = 0; i < nw; i++)
    begin
      w = {24'hb0c0d0, 8'(i)};
      c8 = f8(c8, w, 32);
      bd = {w, bd[63:32]};
      send(wk_data, st, w, 1'b0);
    end
    w = 32'h002522fc;
    w[31:24] = rev8(f8(c8, w, 24)) ^ {7'h0, bad};
    ok = !bad && sq && nw == 2;
    send(wk_end_bc, st, w, sq);
    fin(bad, ok, 1'b0);
    if (ok)
      check(bc_data, bd);
  endtask

  // Wait for the sink to catch up, then compare new words
  task automatic drain(string nm);
    int n;
    n = 0;
    while (frbc_frame_sink_inst.cnt != exp_w.size() && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 400)
    begin
      err_total++;
      end_of_test();
    end
    repeat (4) @(posedge clock);
    check(64'(frbc_frame_sink_inst.cnt), 64'(exp_w.size()));
    for (int i = seen; i < exp_w.size(); i++)
      check(frbc_frame_sink_inst.got[i], exp_w[i]);
    seen = exp_w.size();
    $display("test %0s done", nm);
  endtask

  task automatic t_data();
    df_start();
    df_words(3);
    check(fd_valid, 1'b0);
    df_end(1'b0, 1'b1, 1'b1);
    df_start();
    df_words(2);
    df_end(1'b1, 1'b1, 1'b1);
    df_start();
    df_words(2);
    df_end(1'b0, 1'b0, 1'b1);
    df_start();
    df_words(2);
    df_start();
    df_words(1);
    df_end(1'b0, 1'b1, 1'b1);
    drain("data");
  endtask

  task automatic t_nested();
    df_start();
    df_words(2);
    bcast(broadcast_in_data_state, 2, 1'b0, 1'b1);
    df_words(1);
    df_end(1'b0, 1'b1, 1'b1);
    drain("nested");
  endtask

  task automatic t_bcast();
    send(wk_start_bc, broadcast_frame_state, 32'h060504fc, 1'b0);
    send(wk_data, broadcast_frame_state, 32'h77, 1'b0);
    bcast(broadcast_frame_state, 2, 1'b0, 1'b1);
    bcast(broadcast_frame_state, 3, 1'b0, 1'b1);
    bcast(broadcast_frame_state, 2, 1'b1, 1'b1);
    bcast(broadcast_frame_state, 2, 1'b0, 1'b0);
    drain("bcast");
  endtask

  task automatic t_ctrl();
    frbc_kind_t  ks [4];
    logic [31:0] e;
    ks = '{wk_flow_credit, wk_ack, wk_nack, wk_full};
    for (int i = 0; i < 8; i++)
    begin
      e = 32'h004433fc;
      e[31:24] = rev8(f8(CRC8_INIT, e, 24)) ^ {7'h0, i[0]};
      send(ks[i / 2], no_frame_state, e, 1'b1);
      fin(i[0], 1'b0, (i < 2) && !i[0]);
    end
    drain("ctrl");
  endtask

  task automatic t_flush();
    for (int i = 0; i < 4; i++)
    begin
      df_start();
      df_words(2);
      #1;
      rx_valid = 1'b0;
      cold_reset = (i == 0);
      warm_reset = (i == 1);
      remote_flush = (i == 2);
      @(posedge clock);
      #1;
      {cold_reset, warm_reset, remote_flush} = 3'h0;
      if (i == 3)
        send(wk_other, no_frame_state, 32'h0, 1'b0);
      df_end(1'b0, 1'b1, 1'b0);
      drain("flush");
    end
  endtask

  task automatic t_fill();
    mode = 2'h2;
    df_start();
    df_words(D - 1);
    df_end(1'b0, 1'b1, 1'b1);
    df_start();
    df_words(1);
    #1;
    check(rx_ready, 1'b0);
    mode = 2'h1;
    df_end(1'b0, 1'b1, 1'b1);
    drain("fill");
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    rstn = 1'b0;
    rx_valid = 1'b0;
    rx_word = '{wk_other, 4'h0, 32'h0};
    id_state = no_frame_state;
    seq_ok = 1'b0;
    {cold_reset, warm_reset, remote_flush} = 3'h0;
    mode = 2'h0;
    err_total = 0;
    num_checks = 0;
    seen = 0;
    repeat (10) @(posedge clock);
    #1;
    rstn = 1'b1;
    check({rx_ready, fd_valid, bc_valid, fct_valid, crc_error},
          64'h10);
    check(bc_data, 64'h0);
    @(posedge clock);
    t_data();
    t_nested();
    t_bcast();
    t_ctrl();
    t_flush();
    t_fill();
    end_of_test();
  end
endmodule

`default_nettype wire
